//--- bench/swl_pins_model.sv
// Far-side model: wake pins, external reset pin and supply comparator
`timescale 1ns/1ps
module swl_pins_model
  import swl_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [SWL_PINS-1:0] lvl_in,
  input wire logic rst_low_in,
  input wire logic below_in,
  output logic [SWL_PINS-1:0] pins_out,
  output logic reset_pin_n_out,
  output logic supply_below_out
);
  initial
  begin
    pins_out = '0;
    reset_pin_n_out = 1'b1;
    supply_below_out = 1'b0;
  end
  // Levels move off the sampling edge, as unrelated pins would
  always @(negedge mclk_in)
  begin
    pins_out <= lvl_in;
    reset_pin_n_out <= !rst_low_in;
    supply_below_out <= below_in;
  end
endmodule

//--- bench/swl_stop_wake_test.sv
// Self-checking bench for the stop-wake and supply-low block
`timescale 1ns/1ps
module swl_stop_wake_test
  import swl_pkg::*;
;
  typedef struct {logic [7:0] ctl; logic blw; logic ien; logic [7:0] exp;} swl_row_t;
  logic mclk_in = 0, rst_n_in = 0, rst_low = 0, below = 0, stop_req = 0, irq_on = 0;
  logic sup_ien = 0, clr = 0, stp, rel, sysrst, sirq, rpin, sblw;
  logic [7:0] lvl = 0, wen = 0, pien = 0, ctl = 0, latch, pirq, pins, rec_latch;
  swl_status_t st;
  int fail_count = 0, n_checks = 0, sr_cnt = 0, k;
  bit seen;
  swl_row_t rows [4] = '{'{8'h10, 1, 1, 8'h03}, '{8'h10, 0, 1, 8'h00},
    '{8'h00, 1, 1, 8'h00}, '{8'h10, 1, 0, 8'h02}};
  swl_pins_model i_swl_pins_model (.mclk_in(mclk_in), .lvl_in(lvl), .rst_low_in(rst_low),
    .below_in(below), .pins_out(pins), .reset_pin_n_out(rpin), .supply_below_out(sblw));
  swl_stop_wake i_swl_stop_wake (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pins_in(pins),
    .wake_en_in(wen), .pin_irq_en_in(pien), .reset_pin_n_in(rpin), .supply_below_in(sblw),
    .pwr_ctl_in(ctl), .stop_req_in(stop_req), .irq_enabled_in(irq_on),
    .supply_irq_en_in(sup_ien), .wake_cause_clr_in(clr), .stop_out(stp),
    .clk_release_out(rel), .port_input_latch_out(latch), .pin_irq_out(pirq),
    .system_reset_out(sysrst), .reset_cause_register_out(st), .supply_irq_out(sirq));
  initial
  begin
    forever #2.5 mclk_in = !mclk_in;
  end
  always @(posedge mclk_in)
    if (sysrst === 1'b1)
      sr_cnt++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic enter_stop();
    stop_req = 1;
    cyc(1);
    stop_req = 0;
    cyc(4);
  endtask
  // Bounded wait for the recovery terminal pulse
  task automatic wait_rel();
    seen = 0;
    for (int i = 0; i < 100 && !seen; i++)
    begin
      @(posedge mclk_in);
      #1;
      seen = (rel === 1'b1);
    end
    // Latch as written by the release edge, before run mode copies the pins
    @(posedge mclk_in);
    #1;
    rec_latch = latch;
    cyc(2);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    cyc(8);
    rst_n_in = 1;
    cyc(2);
    chk({stp, st.wake_cause, latch}, 8'h00);
    foreach (rows[i])
    begin
      ctl = rows[i].ctl;
      below = rows[i].blw;
      sup_ien = rows[i].ien;
      cyc(5);
      chk({st.supply_low_flag, sirq}, rows[i].exp);
    end
    below = 0;
    wen = 8'h01;
    pien = 8'h01;
    enter_stop();
    lvl = 8'h82;
    cyc(80);
    chk(stp, 1);
    lvl = 8'h83;
    wait_rel();
    chk(seen, 1);
    chk({stp, st.wake_cause}, 8'h01);
    chk(rec_latch, 8'h01);
    chk(latch, 8'h83);
    chk(pirq, 8'h00);
    irq_on = 1;
    #1;
    chk(pirq, 8'h01);
    cyc(1);
    chk(pirq, 8'h00);
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(1);
    chk(st.wake_cause, 0);
    enter_stop();
    lvl = 8'h82;
    cyc(3);
    lvl = 8'h83;
    cyc(10);
    chk(latch, 8'h83);
    wait_rel();
    chk(seen, 1);
    chk(pirq, 8'h00);
    chk(rec_latch, 8'h83);
    enter_stop();
    rst_low = 1;
    cyc(10);
    rst_low = 0;
    cyc(10);
    chk(sr_cnt, 0);
    rst_low = 1;
    cyc(30);
    rst_low = 0;
    chk(sr_cnt > 0, 1);
    rst_n_in = 0;
    cyc(8);
    rst_n_in = 1;
    cyc(2);
    chk({stp, st.wake_cause}, 8'h00);
    tally_and_finish();
  end
endmodule

//--- hw/swl_pkg.sv
// Package: constants and carrier types for the stop-wake and supply-low block
package swl_pkg;
  localparam int SWL_PINS = 8;
  localparam int SWL_PWR_DET_EN_BIT = 4;
  localparam logic [7:0] SWL_PWR_CTL_RST = 8'h00;
  localparam logic [SWL_PINS-1:0] SWL_PINS_RST = 8'h00;
  // Stop-recovery delay, as printed in cycles of the system clock
  localparam logic [15:0] SWL_RECOVERY_CYC = 16'h0040;
  // Reset pin glitch filter: least qualifying low width in ns
  localparam int SWL_RST_MIN_NS = 100;
  localparam int SWL_CLK_NS = 5;
  localparam logic [7:0] SWL_RST_FILT_CYC =
    8'((SWL_RST_MIN_NS + SWL_CLK_NS - 1) / SWL_CLK_NS);
  localparam logic [7:0] SWL_FILT_ZERO = 8'h00;
  localparam logic [15:0] SWL_CNT_ZERO = 16'h0000;

  typedef enum logic [1:0]
  {
    SWL_RUN = 2'b00,
    SWL_STOP = 2'b01,
    SWL_RECOVER = 2'b11
  } swl_state_t;

  typedef struct packed
  {
    logic wake_cause;
    logic supply_low_flag;
  } swl_status_t;
endpackage

//--- hw/swl_reset_filter.sv
// Glitch filter for the external active-low reset pin
`timescale 1ns/1ps
module swl_reset_filter
  import swl_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pin_low_in,
  output logic reset_req_out
);
  logic [7:0] low_cnt;
  logic done;
  logic [7:0] next_low_cnt;

  assign done = (low_cnt == SWL_RST_FILT_CYC);
  assign next_low_cnt = !pin_low_in ? SWL_FILT_ZERO : (done ? low_cnt : 8'(low_cnt + 8'h01));

  // Short low pulses clear the count before it qualifies
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      low_cnt <= SWL_FILT_ZERO;
      reset_req_out <= 1'b0;
    end
    else
    begin
      low_cnt <= next_low_cnt;
      reset_req_out <= pin_low_in && (next_low_cnt == SWL_RST_FILT_CYC);
    end
  end

  a_filter_qualify: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    reset_req_out |-> $past(pin_low_in))
    else $error("reset request without low pin");
endmodule

//--- hw/swl_stop_wake.sv
// Stop-state wake, wake cause and supply-low flag logic
`timescale 1ns/1ps
module swl_stop_wake
  import swl_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [SWL_PINS-1:0] pins_in,
  input wire logic [SWL_PINS-1:0] wake_en_in,
  input wire logic [SWL_PINS-1:0] pin_irq_en_in,
  input wire logic reset_pin_n_in,
  input wire logic supply_below_in,
  input wire logic [7:0] pwr_ctl_in,
  input wire logic stop_req_in,
  input wire logic irq_enabled_in,
  input wire logic supply_irq_en_in,
  input wire logic wake_cause_clr_in,
  output logic stop_out,
  output logic clk_release_out,
  output logic [SWL_PINS-1:0] port_input_latch_out,
  output logic [SWL_PINS-1:0] pin_irq_out,
  output logic system_reset_out,
  output swl_status_t reset_cause_register_out,
  output logic supply_irq_out
);
  swl_state_t state;
  swl_state_t next_state;
  logic [SWL_PINS-1:0] pin_s1;
  logic [SWL_PINS-1:0] pin_s2;
  logic [SWL_PINS-1:0] snap;
  logic [SWL_PINS-1:0] pend_irq;
  logic rst_s1;
  logic rst_s2;
  logic sup_s1;
  logic sup_s2;
  logic [15:0] rec_cnt;
  logic wake_cause;
  logic supply_low_flag;
  logic filt_reset;
  logic pin_change;
  logic rec_done;
  logic [SWL_PINS-1:0] changed;
  logic [SWL_PINS-1:0] held;
  logic det_en;

  swl_reset_filter u_filter
  (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pin_low_in(!rst_s2),
    .reset_req_out(filt_reset)
  );

  assign det_en = pwr_ctl_in[SWL_PWR_DET_EN_BIT];
  assign changed = (pin_s2 ^ snap) & wake_en_in;
  assign pin_change = (state == SWL_STOP) && (|changed);
  assign rec_done = (state == SWL_RECOVER) && (rec_cnt == SWL_CNT_ZERO);
  // A pin counts only if it still differs from the snapshot at terminal count
  assign held = changed;

  always_comb
  begin
    next_state = state;
    case (state)
      SWL_RUN: if (stop_req_in) next_state = SWL_STOP;
      SWL_STOP: if (pin_change) next_state = SWL_RECOVER;
      SWL_RECOVER: if (rec_done) next_state = SWL_RUN;
      default: next_state = SWL_RUN;
    endcase
  end

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge mclk_in)
  begin
    pin_s1 <= pins_in;
    pin_s2 <= pin_s1;
    rst_s1 <= reset_pin_n_in;
    rst_s2 <= rst_s1;
    sup_s1 <= supply_below_in;
    sup_s2 <= sup_s1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || filt_reset && state != SWL_RUN)
    begin
      state <= SWL_RUN;
      snap <= SWL_PINS_RST;
      port_input_latch_out <= SWL_PINS_RST;
      pend_irq <= SWL_PINS_RST;
      rec_cnt <= SWL_CNT_ZERO;
      wake_cause <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == SWL_RUN)
        port_input_latch_out <= pin_s2;
      else if (rec_done)
        port_input_latch_out <= (port_input_latch_out & ~held) | (pin_s2 & held);
      if (state == SWL_RUN && stop_req_in)
        snap <= pin_s2;
      if (pin_change)
        rec_cnt <= SWL_RECOVERY_CYC;
      else if (state == SWL_RECOVER && rec_cnt != SWL_CNT_ZERO)
        rec_cnt <= rec_cnt - 16'h0001;
      if (rec_done)
        pend_irq <= pend_irq | (held & pin_irq_en_in);
      else if (irq_enabled_in && state == SWL_RUN)
        pend_irq <= SWL_PINS_RST;
      // Set wins over a software clear in the same cycle
      if (pin_change)
        wake_cause <= 1'b1;
      else if (wake_cause_clr_in)
        wake_cause <= 1'b0;
    end
  end

  // Live, unlatched; no software clear, only the detector enable (pwr_ctl_in bit 4) gates it
  assign supply_low_flag = det_en && sup_s2;
  assign supply_irq_out = supply_low_flag && supply_irq_en_in;
  assign pin_irq_out = (irq_enabled_in && state == SWL_RUN) ? pend_irq : SWL_PINS_RST;
  assign stop_out = (state != SWL_RUN);
  assign clk_release_out = rec_done;
  assign system_reset_out = filt_reset && (state != SWL_RUN);
  assign reset_cause_register_out = '{wake_cause: wake_cause, supply_low_flag: supply_low_flag};

  a_wake_sets_cause: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pin_change && !filt_reset |=> wake_cause)
    else $error("wake cause not set");
  a_stop_to_recover: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pin_change && !filt_reset |=> state == SWL_RECOVER)
    else $error("no recovery on pin change");
  a_latch_frozen: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == SWL_STOP && $past(state) == SWL_STOP |-> $stable(port_input_latch_out))
    else $error("input latch moved in stop");
  a_flag_live: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    reset_cause_register_out.supply_low_flag == (sup_s2 && pwr_ctl_in[SWL_PWR_DET_EN_BIT]))
    else $error("supply flag not live");
  a_det_disabled: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !pwr_ctl_in[4] |-> !supply_irq_out)
    else $error("irq with detector off");
  a_sup_irq: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    supply_irq_en_in && reset_cause_register_out.supply_low_flag |-> supply_irq_out)
    else $error("supply irq missing");
  a_reset_in_stop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    system_reset_out |=> state == SWL_RUN)
    else $error("stop not left on reset");
  a_recover_count: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pin_change && !filt_reset |=> rec_cnt == SWL_RECOVERY_CYC)
    else $error("recovery count not loaded");

  // Recovery counter and release strobe
  a_release_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    clk_release_out |=> !clk_release_out)
    else $error("release pulse too long");
  a_release_state: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    clk_release_out |-> state == SWL_RECOVER)
    else $error("release outside recovery");
  a_count_falls: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == SWL_RECOVER && rec_cnt != SWL_CNT_ZERO && !system_reset_out
    |=> rec_cnt == $past(rec_cnt) - 16'h0001)
    else $error("recovery count not falling");

  // Stop entry and stop holding
  a_stop_entry: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == SWL_RUN && stop_req_in |=> state == SWL_STOP)
    else $error("stop request not taken");
  a_stop_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == SWL_STOP && !pin_change && !system_reset_out |=> state == SWL_STOP)
    else $error("stop left without cause");

  // Input latch: only waking pins that held are written at release
  a_latch_recover: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    state == SWL_RECOVER && !rec_done && !system_reset_out
    |=> $stable(port_input_latch_out))
    else $error("input latch moved in recovery");
  a_latch_release: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rec_done && !system_reset_out |=> (port_input_latch_out & ~$past(held))
    == ($past(port_input_latch_out) & ~$past(held)))
    else $error("unheld pin written at release");
  a_irq_pending: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !rec_done && !(irq_enabled_in && state == SWL_RUN) && !system_reset_out
    |=> pend_irq == $past(pend_irq))
    else $error("pin irq pending moved");

  // Pin interrupts only reach the CPU once it runs with interrupts on
  a_pin_irq_masked: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !irq_enabled_in |-> pin_irq_out == SWL_PINS_RST)
    else $error("pin irq while masked");
  a_pin_irq_stop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    stop_out |-> pin_irq_out == SWL_PINS_RST)
    else $error("pin irq during stop");

  // Wake cause: software clear loses to a new wake
  a_cause_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wake_cause_clr_in && !pin_change && !system_reset_out |=> !wake_cause)
    else $error("wake cause not cleared");
  a_cause_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wake_cause && !wake_cause_clr_in && !system_reset_out |=> wake_cause)
    else $error("wake cause dropped");

  // Supply flag and its interrupt
  a_flag_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    det_en && sup_s2 |-> reset_cause_register_out.supply_low_flag)
    else $error("supply flag not set");
  a_flag_no_det: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !det_en |-> !reset_cause_register_out.supply_low_flag)
    else $error("supply flag with detector off");
  a_sup_irq_gated: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    supply_irq_out |-> supply_irq_en_in && reset_cause_register_out.supply_low_flag)
    else $error("supply irq without cause");

  // The filtered reset pin never resets a running core from here
  a_reset_only_stop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    system_reset_out |-> stop_out)
    else $error("system reset outside stop");
endmodule
